// ---- shared/wave_fault_map.vh ----
`ifndef WAVE_FAULT_MAP_VH
`define WAVE_FAULT_MAP_VH
// Register offsets on the core's special function register port
`define ADDR_WAVE_ONE_LOW   8'hE2
`define ADDR_WAVE_ONE_MID   8'hE3
`define ADDR_WAVE_ONE_HIGH  8'hE4
`define ADDR_WAVE_TWO_LOW   8'hE5
`define ADDR_WAVE_TWO_MID   8'hE6
`define ADDR_WAVE_TWO_HIGH  8'hE7
`define ADDR_ACC_CONFIG     8'h0F
`define ADDR_IRQ_EN_HIGH    8'hDB
`define ADDR_IRQ_ST_HIGH    8'hDE
`define ADDR_IRQ_EN_LOW     8'hD9
`define ADDR_IRQ_ST_LOW     8'hDC
`define ADDR_CAL_MODE       8'h3D
`define ADDR_WAVE_MODE      8'h0D
// Field positions
`define BIT_ACTIVE_SEL      7
`define BIT_FAULT_POLARITY  6
`define BIT_SAMPLE_READY    5
`define BIT_FAULT_CHANGE    5
`define BIT_FORCE_PHASE     4
`define BIT_FORCE_NEUTRAL   5
// Timing, code scales and reset values
`define MOD_DIV             5
`define SAMPLE_DIV          160
`define FULL_SCALE_CODE     24'h28F5C2
`define VOLT_FULL_SCALE     24'h0028F5
`define MAX_CODE            24'h400000
`define AVG_TIME_MS         1000
`define CLK_MHZ             100
`define AVG_CYCLES          (`AVG_TIME_MS * 1000 * `CLK_MHZ)
`define ACC_CONFIG_RESET    8'h00
`define WAVE_MODE_RESET     8'h00
`endif

// ---- core/adc_wave_fault_select.v ----
`timescale 1ns/1ns
`include "wave_fault_map.vh"
module adc_wave_fault_select
#(
  parameter AVG_CYCLES = `AVG_CYCLES,  // Fault averaging window
  parameter MOD_DIV    = `MOD_DIV,     // Modulator clock divider
  parameter SAMPLE_DIV = `SAMPLE_DIV   // Base sample divider
)
(
  input  wire        mclk,           // Metering clock
  input  wire        rst,            // Async reset, high
  input  wire        battery_power_state, // Low power state
  input  wire        sleep_power_state,   // Sleep state
  input  wire        bit_current,    // Current modulator bit, async
  input  wire        bit_voltage,    // Voltage modulator bit, async
  input  wire        bit_phase,      // Phase current modulator bit
  input  wire        bit_neutral,    // Neutral current modulator bit
  input  wire [7:0]  sfr_addr,       // Register address
  input  wire        sfr_wr,         // Write strobe
  input  wire        sfr_rd,         // Read strobe
  input  wire [7:0]  sfr_wdata,      // Write data
  output reg  [7:0]  sfr_rdata,      // Read data
  output wire        mod_clk_en,     // Modulator sample pulse
  output wire        meter_irq,      // Pending metering interrupt
  output wire        neutral_in_use  // Measurement uses neutral
);
  localparam ST_NORMAL = 2'b01;
  localparam ST_FAULT  = 2'b10;
  localparam [23:0] V_FLOOR = `VOLT_FULL_SCALE * 3 / 1000;

  // Bit stream to signed step: 1 -> +1, 0 -> -1
  function [23:0] step;
    input b;
    begin
      step = b ? 24'h000001 : 24'hFFFFFF;
    end
  endfunction

  // Clamp to allowed code span
  function [23:0] clamp;
    input [23:0] v;
    begin
      if (!v[23] && v > `MAX_CODE)
        clamp = `MAX_CODE;
      else if (v[23] && v < (24'h000000 - `MAX_CODE))
        clamp = 24'h000000 - `MAX_CODE;
      else
        clamp = v;
    end
  endfunction

  // Absolute value of a decimated code
  function [23:0] mag;
    input [23:0] v;
    begin
      mag = v[23] ? (24'h000000 - v) : v;
    end
  endfunction

  reg  [3:0]  sync1_q;
  reg  [3:0]  sync2_q;
  reg  [7:0]  mod_cnt_q;
  reg  [7:0]  dec_cnt_q;
  reg  [23:0] acc_i_q;
  reg  [23:0] acc_v_q;
  reg  [23:0] acc_a_q;
  reg  [23:0] acc_b_q;
  reg  [23:0] smp_i_q;
  reg  [23:0] smp_v_q;
  reg  [2:0]  rate_cnt_q;
  reg  [23:0] wave1_q;
  reg  [23:0] wave2_q;
  reg  [7:0]  wave_mode_q;
  reg  [7:0]  acc_cfg_q;
  reg  [7:0]  irq_en_high_q;
  reg  [7:0]  irq_en_low_q;
  reg  [7:0]  cal_mode_q;
  reg         sample_flag_q;
  reg         fault_flag_q;
  reg  [31:0] avg_cnt_q;
  reg  [31:0] sum_a_q;
  reg  [31:0] sum_b_q;
  reg  [23:0] peak_v_q;
  reg  [2:0]  cond_q;
  reg  [1:0]  fstate_q;
  reg         auto_neutral_q;

  wire        powered = !battery_power_state && !sleep_power_state;
  wire        mod_tick = powered && (mod_cnt_q == MOD_DIV - 1);
  wire        dec_tick = mod_tick &&
                         (dec_cnt_q == SAMPLE_DIV / MOD_DIV - 1);
  wire [2:0]  rate_mask = (3'd1 << wave_mode_q[1:0]) - 3'd1;
  wire        wave_tick = dec_tick && ((rate_cnt_q & rate_mask) == 3'd0);
  wire        avg_done = (avg_cnt_q == AVG_CYCLES - 1);
  wire        f_phase = cal_mode_q[`BIT_FORCE_PHASE];
  wire        f_neutral = cal_mode_q[`BIT_FORCE_NEUTRAL];
  wire [31:0] act = auto_neutral_q ? sum_b_q : sum_a_q;
  wire [31:0] inact = auto_neutral_q ? sum_a_q : sum_b_q;
  wire [31:0] diff = (act > inact) ? act - inact : inact - act;
  wire        big_diff = diff > (act >> 4);
  wire        swap_margin = (inact > act) && (inact - act > (act >> 4));
  // Window peak against 0.3 percent of voltage full scale
  wire        v_ok = peak_v_q > V_FLOOR;
  wire [2:0]  cond = {v_ok, big_diff, swap_margin};
  wire        settled = (cond == cond_q);
  wire        clr_sample = sfr_wr && sfr_addr == `ADDR_IRQ_ST_HIGH &&
                           !sfr_wdata[`BIT_SAMPLE_READY];
  wire        clr_fault = sfr_wr && sfr_addr == `ADDR_IRQ_ST_LOW &&
                          !sfr_wdata[`BIT_FAULT_CHANGE];
  reg         fault_event_q;

  assign mod_clk_en = mod_tick;
  // Force applies only with exactly one force bit set
  assign neutral_in_use = (f_phase ^ f_neutral) ? f_neutral
                          : auto_neutral_q;
  assign meter_irq = (sample_flag_q &&
                      irq_en_high_q[`BIT_SAMPLE_READY]) ||
                     (fault_flag_q && irq_en_low_q[`BIT_FAULT_CHANGE]);

  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      sync1_q <= 4'h0;
      sync2_q <= 4'h0;
    end
    else
    begin
      sync1_q <= {bit_neutral, bit_phase, bit_voltage, bit_current};
      sync2_q <= sync1_q;
    end
  end

  // Decimation: boxcar of 32 modulator bits scaled to code span
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      mod_cnt_q <= 8'h00;
      dec_cnt_q <= 8'h00;
      acc_i_q   <= 24'h000000;
      acc_v_q   <= 24'h000000;
      acc_a_q   <= 24'h000000;
      acc_b_q   <= 24'h000000;
      smp_i_q   <= 24'h000000;
      smp_v_q   <= 24'h000000;
      rate_cnt_q <= 3'd0;
    end
    else if (powered)
    begin
      mod_cnt_q <= mod_tick ? 8'h00 : mod_cnt_q + 8'h01;
      if (mod_tick)
      begin
        if (dec_tick)
        begin
          dec_cnt_q <= 8'h00;
          // Scale 32-bit average to full-scale code magnitudes
          smp_i_q <= clamp(acc_i_q * 24'd83886);
          smp_v_q <= clamp(acc_v_q * 24'd327);
          acc_i_q <= step(sync2_q[0]);
          acc_v_q <= step(sync2_q[1]);
          acc_a_q <= step(sync2_q[2]);
          acc_b_q <= step(sync2_q[3]);
          rate_cnt_q <= rate_cnt_q + 3'd1;
        end
        else
        begin
          dec_cnt_q <= dec_cnt_q + 8'h01;
          acc_i_q <= acc_i_q + step(sync2_q[0]);
          acc_v_q <= acc_v_q + step(sync2_q[1]);
          acc_a_q <= acc_a_q + step(sync2_q[2]);
          acc_b_q <= acc_b_q + step(sync2_q[3]);
        end
      end
    end
  end

  // Averaged magnitudes for fault compare; runs beside waveform path
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      avg_cnt_q <= 32'h0;
      sum_a_q <= 32'h0;
      sum_b_q <= 32'h0;
      peak_v_q <= 24'h000000;
      cond_q <= 3'b000;
      fstate_q <= ST_NORMAL;
      auto_neutral_q <= 1'b0;
      fault_event_q <= 1'b0;
    end
    else
    begin
      fault_event_q <= 1'b0;
      // Input magnitudes only; waveform reads never touch these sums
      if (dec_tick)
      begin
        sum_a_q <= sum_a_q + {8'h00, mag(acc_a_q)};
        sum_b_q <= sum_b_q + {8'h00, mag(acc_b_q)};
        if (mag(smp_v_q) > peak_v_q)
          peak_v_q <= mag(smp_v_q);
      end
      avg_cnt_q <= avg_done ? 32'h0 : avg_cnt_q + 32'h1;
      if (avg_done)
      begin
        sum_a_q <= 32'h0;
        sum_b_q <= 32'h0;
        peak_v_q <= 24'h000000;
        cond_q <= cond;
        // Two agreeing windows, so a step in the inputs never acts at once
        if (v_ok && settled)
        begin
          case (fstate_q)
            ST_NORMAL:
              if (big_diff)
              begin
                fstate_q <= ST_FAULT;
                fault_event_q <= !acc_cfg_q[`BIT_FAULT_POLARITY];
                if (swap_margin)
                  auto_neutral_q <= ~auto_neutral_q;
              end
            ST_FAULT:
              if (swap_margin)
                auto_neutral_q <= ~auto_neutral_q;
              else if (!big_diff)
              begin
                fstate_q <= ST_NORMAL;
                fault_event_q <= acc_cfg_q[`BIT_FAULT_POLARITY];
              end
            default:
              fstate_q <= ST_NORMAL;
          endcase
        end
      end
    end
  end

  // Register port, flags, high-byte latch
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      wave_mode_q <= `WAVE_MODE_RESET;
      acc_cfg_q <= `ACC_CONFIG_RESET;
      irq_en_high_q <= 8'h00;
      irq_en_low_q <= 8'h00;
      cal_mode_q <= 8'h00;
      sample_flag_q <= 1'b0;
      fault_flag_q <= 1'b0;
      wave1_q <= 24'h000000;
      wave2_q <= 24'h000000;
    end
    else
    begin
      if (sfr_wr)
      begin
        case (sfr_addr)
          `ADDR_WAVE_MODE:   wave_mode_q <= sfr_wdata;
          `ADDR_ACC_CONFIG:  acc_cfg_q <= {1'b0, sfr_wdata[6:0]};
          `ADDR_IRQ_EN_HIGH: irq_en_high_q <= {2'b00, sfr_wdata[5:0]};
          `ADDR_IRQ_EN_LOW:  irq_en_low_q <= {2'b00, sfr_wdata[5:0]};
          `ADDR_CAL_MODE:    cal_mode_q <= sfr_wdata;
          default:           cal_mode_q <= cal_mode_q;
        endcase
      end
      // Set wins over a same-cycle clear
      if (wave_tick)
        sample_flag_q <= 1'b1;
      else if (clr_sample)
        sample_flag_q <= 1'b0;
      if (fault_event_q)
        fault_flag_q <= 1'b1;
      else if (clr_fault)
        fault_flag_q <= 1'b0;
      if (sfr_rd && (sfr_addr == `ADDR_WAVE_ONE_HIGH ||
                     sfr_addr == `ADDR_WAVE_TWO_HIGH))
      begin
        wave1_q <= smp_i_q;
        wave2_q <= smp_v_q;
      end
    end
  end

  // Registered read data; high byte returns the freshly latched value
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
      sfr_rdata <= 8'h00;
    else if (sfr_rd)
    begin
      case (sfr_addr)
        `ADDR_WAVE_ONE_LOW:  sfr_rdata <= wave1_q[7:0];
        `ADDR_WAVE_ONE_MID:  sfr_rdata <= wave1_q[15:8];
        `ADDR_WAVE_ONE_HIGH: sfr_rdata <= smp_i_q[23:16];
        `ADDR_WAVE_TWO_LOW:  sfr_rdata <= wave2_q[7:0];
        `ADDR_WAVE_TWO_MID:  sfr_rdata <= wave2_q[15:8];
        `ADDR_WAVE_TWO_HIGH: sfr_rdata <= smp_v_q[23:16];
        `ADDR_WAVE_MODE:     sfr_rdata <= wave_mode_q;
        `ADDR_ACC_CONFIG:    sfr_rdata <= {neutral_in_use,
                                           acc_cfg_q[6:0]};
        `ADDR_IRQ_EN_HIGH:   sfr_rdata <= irq_en_high_q;
        `ADDR_IRQ_EN_LOW:    sfr_rdata <= irq_en_low_q;
        `ADDR_IRQ_ST_HIGH:   sfr_rdata <= {2'b00, sample_flag_q, 5'h00};
        `ADDR_IRQ_ST_LOW:    sfr_rdata <= {2'b00, fault_flag_q, 5'h00};
        `ADDR_CAL_MODE:      sfr_rdata <= cal_mode_q;
        default:             sfr_rdata <= 8'h00;
      endcase
    end
  end
endmodule

// ---- tb/mod_source.sv ----
`timescale 1ns/1ns
module mod_source
(
  input  wire       mclk,  // Clock
  input  wire       rst,   // Reset
  input  wire       tick,  // Modulator slot pulse
  input  wire [3:0] hi,    // Channel held at ones
  input  wire [3:0] lo,    // Channel alternating
  output wire [3:0] bits   // Current, voltage, phase, neutral
);
  reg tog_q;
  // Flip per slot so a mid-scale stream never looks stuck
  always @(posedge mclk or posedge rst)
    if (rst)
      tog_q <= 1'b0;
    else if (tick)
      tog_q <= ~tog_q;
  assign bits = hi | (lo & {4{tog_q}});
endmodule

// ---- tb/adc_wave_fault_properties.sv ----
`timescale 1ns/1ns
module adc_wave_fault_props
(
  input logic       mclk,                // Clock
  input logic       rst,                 // Reset
  input logic       battery_power_state, // Low power
  input logic       sleep_power_state,   // Sleep
  input logic [7:0] sfr_addr,            // Address
  input logic       sfr_wr,              // Write
  input logic [7:0] sfr_wdata,           // Write data
  input logic       sfr_rd,              // Read
  input logic [7:0] sfr_rdata,           // Read data
  input logic       mod_clk_en,          // Slot pulse
  input logic       meter_irq,           // Interrupt
  input logic       neutral_in_use       // Neutral used
);
  wire off = battery_power_state | sleep_power_state;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  property p_mod_gap; mod_clk_en |=> !mod_clk_en [*4]; endproperty
  a_mod_gap: assert property (p_mod_gap)
    else $error("slot pulse too soon");
  property p_mod_due; mod_clk_en ##1 !off [*5] |-> mod_clk_en; endproperty
  a_mod_due: assert property (p_mod_due)
    else $error("slot pulse late");
  property p_pwr_off; off |-> !mod_clk_en; endproperty
  a_pwr_off: assert property (p_pwr_off)
    else $error("converter runs in low power");
  property p_unmap; sfr_rd && sfr_addr == 8'h55 |=> sfr_rdata == 8'h00;
  endproperty
  a_unmap: assert property (p_unmap)
    else $error("unmapped read not zero");
  property p_irq_hold; meter_irq && !sfr_wr |=> meter_irq; endproperty
  a_irq_hold: assert property (p_irq_hold)
    else $error("interrupt dropped");
  property p_sel_rd;
    sfr_rd && sfr_addr == 8'h0F |=> sfr_rdata[7] == $past(neutral_in_use);
  endproperty
  a_sel_rd: assert property (p_sel_rd)
    else $error("select bit differs from path");
  property p_rst_sel; $fell(rst) |-> !neutral_in_use && !meter_irq;
  endproperty
  a_rst_sel: assert property (p_rst_sel)
    else $error("not phase after reset");
  property p_force;
    sfr_wr && sfr_addr == 8'h3D && sfr_wdata[5:4] == 2'b01 |=> !neutral_in_use;
  endproperty
  a_force: assert property (p_force)
    else $error("phase not forced");
  property p_force_n;
    sfr_wr && sfr_addr == 8'h3D && sfr_wdata[5:4] == 2'b10 |=> neutral_in_use;
  endproperty
  a_force_n: assert property (p_force_n)
    else $error("neutral not forced");
endmodule
bind adc_wave_fault_select adc_wave_fault_props u_props
(.mclk(mclk), .rst(rst), .battery_power_state(battery_power_state),
 .sleep_power_state(sleep_power_state), .sfr_addr(sfr_addr),
 .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd),
 .sfr_rdata(sfr_rdata), .mod_clk_en(mod_clk_en), .meter_irq(meter_irq),
 .neutral_in_use(neutral_in_use));

// ---- tb/adc_wave_fault_select_tb.sv ----
`timescale 1ns/1ns
module adc_wave_fault_select_tb;
  reg         mclk, rst, bps, sps, rd, wr;
  reg  [7:0]  addr, wdata;
  reg  [3:0]  hi, lo;
  reg  [23:0] b, v, w;
  wire [7:0]  rdata;
  wire [3:0]  bits;
  wire        tick, irq, nsel;
  integer     err_total, comparisons, i, t0;
  adc_wave_fault_select #(.AVG_CYCLES(2000)) u_dut
  (.mclk(mclk), .rst(rst), .battery_power_state(bps),
   .sleep_power_state(sps), .bit_current(bits[3]), .bit_voltage(bits[2]),
   .bit_phase(bits[1]), .bit_neutral(bits[0]), .sfr_addr(addr),
   .sfr_wr(wr), .sfr_rd(rd), .sfr_wdata(wdata), .sfr_rdata(rdata),
   .mod_clk_en(tick), .meter_irq(irq), .neutral_in_use(nsel));
  mod_source u_src
  (.mclk(mclk), .rst(rst), .tick(tick), .hi(hi), .lo(lo), .bits(bits));
  task conclude;
    begin
      if (err_total == 0 && comparisons > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  task chk(input [23:0] seen, input [23:0] exp);
    begin
      comparisons = comparisons + 1;
      if (seen !== exp)
      begin
        err_total = err_total + 1;
        $display("MISMATCH %0t saw %h want %h", $time, seen, exp);
      end
    end
  endtask
  task wr8(input [7:0] a, input [7:0] d);
    begin
      @(posedge mclk);
      #1 addr = a;
      wdata = d;
      wr = 1'b1;
      @(posedge mclk);
      #1 wr = 1'b0;
    end
  endtask
  task rd8(input [7:0] a);
    begin
      @(posedge mclk);
      #1 addr = a;
      rd = 1'b1;
      @(posedge mclk);
      #1 rd = 1'b0;
      b = {16'h0000, rdata};
    end
  endtask
  // High byte first so the triple is one coherent sample
  task rdw(input [7:0] a);
    begin
      rd8(a);
      v[23:16] = b[7:0];
      rd8(a - 8'h01);
      v[15:8] = b[7:0];
      rd8(a - 8'h02);
      v[7:0] = b[7:0];
    end
  endtask
  task wait_on(input integer sel, input val, input integer lim);
    integer n;
    begin
      n = 0;
      while ((sel ? nsel : irq) !== val && n < lim)
      begin
        @(posedge mclk);
        #1 n = n + 1;
      end
    end
  endtask
  task rate(input [1:0] code);
    begin
      wr8(8'h0D, {6'h00, code});
      wait_on(0, 1'b1, 3000);
      wr8(8'hDE, 8'h00);
      wait_on(0, 1'b1, 3000);
      t0 = $time;
      wr8(8'hDE, 8'h00);
      wait_on(0, 1'b1, 3000);
      chk(($time - t0) / 10, 24'd160 << code);
    end
  endtask
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  initial
  begin
    repeat (80000) @(posedge mclk);
    err_total = err_total + 1;
    conclude;
  end
  initial
  begin
    rst = 1'b1;
    {bps, sps, rd, wr, addr, wdata, hi, b, v} = 0;
    lo = 4'hF;
    err_total = 0;
    comparisons = 0;
    repeat (5) @(posedge mclk);
    #1 rst = 1'b0;
    rd8(8'h0F);
    chk(b & 24'h80, 24'h00);
    rd8(8'h55);
    chk(b, 24'h00);
    repeat (200) @(posedge mclk);
    rd8(8'hDE);
    chk(b & 24'h20, 24'h20);
    chk({23'h0, irq}, 24'h0);
    wr8(8'hDB, 8'h20);
    chk({23'h0, irq}, 24'h1);
    for (i = 0; i < 4; i = i + 1)
      rate(i[1:0]);
    wr8(8'h0D, 8'h00);
    for (i = 0; i < 2; i = i + 1)
    begin
      {bps, sps} = i ? 2'b01 : 2'b10;
      wr8(8'hDE, 8'h00);
      repeat (400) @(posedge mclk);
      rd8(8'hDE);
      chk(b & 24'h20, 24'h00);
      {bps, sps} = 2'b00;
      wait_on(0, 1'b1, 400);
      chk({23'h0, irq}, 24'h1);
    end
    hi = 4'hC;
    lo = 4'h0;
    repeat (2000) @(posedge mclk);
    rdw(8'hE4);
    w = v;
    chk({23'h0, w[23]}, 24'h0);
    chk({23'h0, w <= 24'h400000 && w != 0}, 24'h1);
    rd8(8'hE4);
    hi = 4'h0;
    repeat (2000) @(posedge mclk);
    rd8(8'hE3);
    v[15:8] = b[7:0];
    rd8(8'hE2);
    v[7:0] = b[7:0];
    chk(v & 24'h00FFFF, w & 24'h00FFFF);
    rdw(8'hE4);
    chk({23'h0, v[23] && (~v + 24'h1) <= 24'h400000}, 24'h1);
    rdw(8'hE7);
    chk({23'h0, v[23]}, 24'h1);
    hi = 4'h1;
    lo = 4'hE;
    repeat (6000) @(posedge mclk);
    chk({23'h0, nsel}, 24'h0);
    hi = 4'h5;
    lo = 4'hA;
    repeat (500) @(posedge mclk);
    chk({23'h0, nsel}, 24'h0);
    wait_on(1, 1'b1, 8000);
    chk({23'h0, nsel}, 24'h1);
    rd8(8'h0F);
    chk(b & 24'h80, 24'h80);
    rd8(8'hDC);
    chk(b & 24'h20, 24'h20);
    wr8(8'hDC, 8'h00);
    wr8(8'h0F, 8'h40);
    hi = 4'h7;
    lo = 4'h8;
    repeat (7000) @(posedge mclk);
    chk({23'h0, nsel}, 24'h1);
    wr8(8'h3D, 8'h10);
    chk({23'h0, nsel}, 24'h0);
    wr8(8'h3D, 8'h00);
    chk({23'h0, nsel}, 24'h1);
    rd8(8'hDC);
    chk(b & 24'h20, 24'h20);
    wr8(8'hDC, 8'h00);
    hi = 4'h6;
    lo = 4'h9;
    wait_on(1, 1'b0, 8000);
    chk({23'h0, nsel}, 24'h0);
    rd8(8'hDC);
    chk(b & 24'h20, 24'h00);
    wr8(8'h3D, 8'h20);
    chk({23'h0, nsel}, 24'h1);
    wr8(8'h3D, 8'h30);
    wait_on(1, 1'b0, 8000);
    chk({23'h0, nsel}, 24'h0);
    conclude;
  end
endmodule
